// *** logic/asrc_cfg.svh ***
// Contract
// - A write happens only while the write strobe and the combined select are both active, from the later start to the first release.
// - Data setup and hold for a write are timed from whichever edge, strobe or select, ends that write.
// - The address stands stable at least 35 ns (fast) or 40 ns (slow) before a write ends.
// - The address may appear at the same moment a write starts, with 0 ns setup.
// - The address may change at the instant a write ends, with 0 ns hold.
// - Write data is valid on the data pins at least 25 ns before the write ends.
// - Write data may be released at the edge that ends the write, with 0 ns hold.
// - A strobe-controlled write with output enable low lasts at least data setup plus the strobe-to-float delay.
// - The memory is deselected before data retention begins, with 0 ns lead.
`ifndef ASRC_CFG_SVH
`define ASRC_CFG_SVH
`define ASRC_CLK_PERIOD_NS        4
`define ASRC_ADDR_W               17
`define ASRC_DATA_W               8
// Slow-grade figures; they also cover the fast grade
`define ASRC_READ_CYCLE_PERIOD_NS  55
`define ASRC_WRITE_CYCLE_PERIOD_NS 55
`define ASRC_ADDR_TO_READ_DATA_NS  55
`define ASRC_OUTPUT_DRIVE_TO_DATA_NS 25
`define ASRC_ADDR_SETUP_TO_WRITE_END_NS 40
`define ASRC_WRITE_STROBE_WIDTH_NS 40
`define ASRC_DATA_SETUP_TO_WRITE_END_NS 25
`define ASRC_STROBE_TO_FLOAT_DELAY_NS 20
`define ASRC_OUTPUT_FLOAT_DELAY_NS 20
`define ASRC_DESELECT_TO_RETENTION_NS 0
`define ASRC_CYC_UP(ns) (((ns) + `ASRC_CLK_PERIOD_NS - 1) / `ASRC_CLK_PERIOD_NS)
`define ASRC_READ_CYC  `ASRC_CYC_UP(`ASRC_READ_CYCLE_PERIOD_NS)
`define ASRC_WRITE_CYC `ASRC_CYC_UP(`ASRC_WRITE_CYCLE_PERIOD_NS)
`define ASRC_SAMPLE_CYC `ASRC_CYC_UP(`ASRC_ADDR_TO_READ_DATA_NS)
`define ASRC_STROBE_CYC `ASRC_CYC_UP(`ASRC_DATA_SETUP_TO_WRITE_END_NS + `ASRC_STROBE_TO_FLOAT_DELAY_NS)
`define ASRC_FLOAT_CYC `ASRC_CYC_UP(`ASRC_OUTPUT_FLOAT_DELAY_NS)
`define ASRC_CNT_W 5
`endif

// *** logic/asrc_ctrl.sv ***
`timescale 1ns/1ps
`include "asrc_cfg.svh"
module asrc_ctrl (
  input  wire logic                    clock,
  input  wire logic                    rstn,
  input  wire logic                    req_valid,
  input  wire logic                    req_write,
  input  wire logic [`ASRC_ADDR_W-1:0] req_addr,
  input  wire logic [`ASRC_DATA_W-1:0] req_wdata,
  output logic                         req_ready,
  output logic                         rsp_valid,
  output logic [`ASRC_DATA_W-1:0]      rsp_rdata,
  input  wire logic                    retain_req,
  output logic                         retain_ok,
  output logic [`ASRC_ADDR_W-1:0]      mem_addr,
  output logic                         select_low_active_n,
  output logic                         select_high_active,
  output logic                         write_strobe_n,
  output logic                         output_enable_n,
  input  wire logic [`ASRC_DATA_W-1:0] mem_data_in,
  output logic [`ASRC_DATA_W-1:0]      mem_data_out,
  output logic                         mem_data_oe_n
);
  localparam logic [`ASRC_CNT_W-1:0] READ_CYC   = `ASRC_CNT_W'(`ASRC_READ_CYC);
  localparam logic [`ASRC_CNT_W-1:0] WRITE_CYC  = `ASRC_CNT_W'(`ASRC_WRITE_CYC);
  localparam logic [`ASRC_CNT_W-1:0] SAMPLE_CYC = `ASRC_CNT_W'(`ASRC_SAMPLE_CYC);
  localparam logic [`ASRC_CNT_W-1:0] STROBE_CYC = `ASRC_CNT_W'(`ASRC_STROBE_CYC);
  localparam logic [`ASRC_CNT_W-1:0] FLOAT_CYC  = `ASRC_CNT_W'(`ASRC_FLOAT_CYC);

  asrc_pkg::asrc_state_t          state_q;
  asrc_pkg::asrc_state_t          state_d;
  logic [`ASRC_CNT_W-1:0]         cnt_q;
  logic [`ASRC_CNT_W-1:0]         cnt_d;
  logic [`ASRC_ADDR_W-1:0]        addr_q;
  logic [`ASRC_ADDR_W-1:0]        addr_d;
  logic [`ASRC_DATA_W-1:0]        wdata_q;
  logic [`ASRC_DATA_W-1:0]        wdata_d;
  logic [`ASRC_DATA_W-1:0]        rdata_q;
  logic [`ASRC_DATA_W-1:0]        rdata_d;
  logic                           rsp_q;
  logic                           rsp_d;
  logic                           sel_q;
  logic                           sel_d;
  logic                           we_q;
  logic                           we_d;
  logic                           oe_q;
  logic                           oe_d;
  logic                           drive_q;
  logic                           drive_d;
  logic                           retain_q;
  logic                           retain_d;
  logic [`ASRC_DATA_W-1:0]        data_sync;
  logic                           take;
  logic                           rd_done;
  logic                           wr_done;

  // Bus data is asynchronous to us; filter each bit
  genvar gi;
  generate
    for (gi = 0; gi < `ASRC_DATA_W; gi++) begin : g_sync
      asrc_sync u_sync (
        .clock   (clock),
        .rstn    (rstn),
        .pin_in  (mem_data_in[gi]),
        .level_q (data_sync[gi])
      );
    end
  endgenerate

  assign req_ready = (state_q == asrc_pkg::ASRC_IDLE) && !retain_req;

  // Phase start and ends; take and wr_done feed the sequencer and pin registers, rd_done feeds all three groups
  assign take    = req_valid && req_ready;
  // Sample after the full access time plus sync latency
  assign rd_done = (state_q == asrc_pkg::ASRC_RD) && (cnt_q == SAMPLE_CYC + `ASRC_CNT_W'(3));
  // Strobe width covers address setup and data setup plus float delay
  assign wr_done = (state_q == asrc_pkg::ASRC_WR) && (cnt_q == STROBE_CYC - `ASRC_CNT_W'(1));

  // Sequencer: cycle phase and its counter
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    unique case (state_q)
      asrc_pkg::ASRC_IDLE: begin
        if (take) begin
          cnt_d = '0;
          if (req_write) begin
            state_d = asrc_pkg::ASRC_WR;
          end else begin
            state_d = asrc_pkg::ASRC_RD;
          end
        end
      end
      asrc_pkg::ASRC_RD: begin
        cnt_d = cnt_q + `ASRC_CNT_W'(1);
        if (rd_done) begin
          state_d = asrc_pkg::ASRC_RD_END;
        end
      end
      asrc_pkg::ASRC_RD_END: begin
        cnt_d = cnt_q + `ASRC_CNT_W'(1);
        // Memory outputs must float before a following write drives the bus
        if (cnt_q >= READ_CYC + `ASRC_CNT_W'(4) + FLOAT_CYC) begin
          state_d = asrc_pkg::ASRC_IDLE;
        end
      end
      asrc_pkg::ASRC_WR: begin
        cnt_d = cnt_q + `ASRC_CNT_W'(1);
        if (wr_done) begin
          state_d = asrc_pkg::ASRC_WR_END;
        end
      end
      asrc_pkg::ASRC_WR_END: begin
        cnt_d = cnt_q + `ASRC_CNT_W'(1);
        if (cnt_q >= WRITE_CYC - `ASRC_CNT_W'(1)) begin
          state_d = asrc_pkg::ASRC_IDLE;
        end
      end
      default: begin
        state_d = asrc_pkg::ASRC_IDLE;
      end
    endcase
  end

  // Answer registers toward the requester
  always_comb begin
    rdata_d  = rdata_q;
    rsp_d    = 1'b0;
    // Deselected already, so retention may start now
    retain_d = (state_q == asrc_pkg::ASRC_IDLE) && retain_req && !sel_q;
    if (rd_done) begin
      rdata_d = data_sync;
      rsp_d   = 1'b1;
    end
  end

  // Pin and data registers toward the memory
  always_comb begin
    addr_d  = addr_q;
    wdata_d = wdata_q;
    sel_d   = sel_q;
    we_d    = we_q;
    oe_d    = oe_q;
    drive_d = drive_q;
    if (take) begin
      addr_d  = req_addr;
      wdata_d = req_wdata;
      sel_d   = 1'b1;
      we_d    = req_write;
      oe_d    = !req_write;
      drive_d = req_write;
    end
    if (rd_done) begin
      sel_d = 1'b0;
      oe_d  = 1'b0;
    end
    // Strobe and select end the write together
    if (wr_done) begin
      we_d  = 1'b0;
      sel_d = 1'b0;
    end
    // Data held one extra cycle past the ending edge; address held until the next request
    if (state_q == asrc_pkg::ASRC_WR_END) begin
      drive_d = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_q <= asrc_pkg::ASRC_IDLE;
      cnt_q   <= '0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rdata_q  <= '0;
      rsp_q    <= 1'b0;
      retain_q <= 1'b0;
    end else begin
      rdata_q  <= rdata_d;
      rsp_q    <= rsp_d;
      retain_q <= retain_d;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      addr_q  <= '0;
      wdata_q <= '0;
      sel_q   <= 1'b0;
      we_q    <= 1'b0;
      oe_q    <= 1'b0;
      drive_q <= 1'b0;
    end else begin
      addr_q  <= addr_d;
      wdata_q <= wdata_d;
      sel_q   <= sel_d;
      we_q    <= we_d;
      oe_q    <= oe_d;
      drive_q <= drive_d;
    end
  end

  assign mem_addr            = addr_q;
  assign select_low_active_n = !sel_q;
  assign select_high_active  = sel_q;
  assign write_strobe_n      = !we_q;
  // Output enable is never low during a write, so the memory never fights us
  assign output_enable_n     = !oe_q;
  assign mem_data_out        = wdata_q;
  assign mem_data_oe_n       = !drive_q;
  assign rsp_valid           = rsp_q;
  assign rsp_rdata           = rdata_q;
  assign retain_ok           = retain_q;
endmodule // asrc_ctrl

// *** logic/asrc_pkg.sv ***
package asrc_pkg;
  typedef enum logic [2:0] {
    ASRC_IDLE   = 3'b000,
    ASRC_RD     = 3'b001,
    ASRC_RD_END = 3'b010,
    ASRC_WR     = 3'b011,
    ASRC_WR_END = 3'b100
  } asrc_state_t;
endpackage

// *** logic/asrc_sync.sv ***
`timescale 1ns/1ps
module asrc_sync (
  input  wire logic clock,
  input  wire logic rstn,
  input  wire logic pin_in,
  output logic      level_q
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic level_d;

  always_comb begin
    level_d = level_q;
    if (s2_q == s3_q) begin
      level_d = s3_q;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s1_q    <= 1'b0;
      s2_q    <= 1'b0;
      s3_q    <= 1'b0;
      level_q <= 1'b0;
    end else begin
      s1_q    <= pin_in;
      s2_q    <= s1_q;
      s3_q    <= s2_q;
      level_q <= level_d;
    end
  end
endmodule // asrc_sync

// *** test/asrc_chk_assertions.sv ***
`timescale 1ns/1ps
`include "asrc_cfg.svh"
module asrc_chk (
  input wire logic                    clock,
  input wire logic                    rstn,
  input wire logic                    rsp_valid,
  input wire logic                    retain_ok,
  input wire logic [`ASRC_ADDR_W-1:0] mem_addr,
  input wire logic                    select_low_active_n,
  input wire logic                    select_high_active,
  input wire logic                    write_strobe_n,
  input wire logic                    output_enable_n,
  input wire logic [`ASRC_DATA_W-1:0] mem_data_out,
  input wire logic                    mem_data_oe_n
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  logic       sel_q;
  logic [4:0] gap_q;
  logic [4:0] gap_d;
  // Saturating count of cycles since the last cycle start
  always_comb begin
    gap_d = (gap_q == 5'h1F) ? gap_q : gap_q + 5'h01;
    if (!select_low_active_n && !sel_q) gap_d = 5'h00;
  end
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      gap_q <= 5'h1F;
      sel_q <= 1'b0;
    end else begin
      gap_q <= gap_d;
      sel_q <= !select_low_active_n;
    end
  end
  sequence s_pulse; (!write_strobe_n)[*8] ##1 (!write_strobe_n)[*4]; endsequence
  sequence s_desel; select_low_active_n && !select_high_active; endsequence
  property p_width; $fell(write_strobe_n) |-> s_pulse; endproperty
  a_width: assert property (p_width) else $error("strobe pulse short");
  property p_wsel; !write_strobe_n |-> !select_low_active_n && select_high_active; endproperty
  a_wsel: assert property (p_wsel) else $error("strobe without select");
  property p_wend; $rose(write_strobe_n) |-> s_desel and !mem_data_oe_n; endproperty
  a_wend: assert property (p_wend) else $error("write end mismatch");
  property p_whold; !write_strobe_n && !$past(write_strobe_n) |-> $stable(mem_addr) && $stable(mem_data_out)
    && !mem_data_oe_n; endproperty
  a_whold: assert property (p_whold) else $error("write address or data moved");
  property p_rex; !output_enable_n |-> write_strobe_n && mem_data_oe_n; endproperty
  a_rex: assert property (p_rex) else $error("read overlaps write");
  property p_rans; $fell(output_enable_n) |-> ##18 rsp_valid; endproperty
  a_rans: assert property (p_rans) else $error("read answer late");
  property p_ret; retain_ok |-> s_desel and write_strobe_n; endproperty
  a_ret: assert property (p_ret) else $error("retention while selected");
  property p_gap; $fell(select_low_active_n) |-> gap_q >= 5'h0D; endproperty
  a_gap: assert property (p_gap) else $error("cycles too close");
endmodule // asrc_chk

// *** test/asrc_mem.sv ***
`timescale 1ns/1ps
module asrc_mem (
  input  wire logic [16:0] mem_addr,
  input  wire logic        sel_n,
  input  wire logic        sel_h,
  input  wire logic        we_n,
  input  wire logic        oe_n,
  input  wire logic [7:0]  host_d,
  input  wire logic        host_oe_n,
  output logic [7:0]       bus
);
  logic [7:0] mem [0:131071];
  logic [7:0] dout = 8'h00;
  logic       drv = 1'b0;
  wire sel = !sel_n && sel_h;
  wire rd = sel && !oe_n && we_n;
  wire wr = sel && !we_n;
  always @(mem_addr or rd) if (rd) begin
    dout <= #10 ~dout;
    // Latest legal answer, so a host that samples early is caught
    dout <= #55 mem[mem_addr];
  end
  // Let go at once, drive late: no overlap on a handover
  always @(posedge rd) drv <= #10 1'b1;
  always @(negedge rd) drv = 1'b0;
  always @(negedge wr) mem[mem_addr] = bus;
  // Floating bus shows a changed value, never the stale one
  assign bus = !host_oe_n ? host_d : (drv ? dout : ~dout);
endmodule // asrc_mem

// *** test/async_sram_cycle_timing_tb.sv ***
`timescale 1ns/1ps
`include "asrc_cfg.svh"
module async_sram_cycle_timing_tb;
  logic        clock = 0, rstn = 0, req_valid = 0, req_write = 0, retain_req = 0;
  logic [16:0] req_addr = '0;
  logic [7:0]  req_wdata = '0;
  wire         req_ready, rsp_valid, retain_ok, sl_n, sh, we_n, oe_n, d_oe_n;
  wire  [16:0] mem_addr;
  wire  [7:0]  rdata, dout, bus;
  int          error_cnt = 0, comparisons = 0;
  asrc_ctrl asrc_ctrl_i (.clock(clock), .rstn(rstn), .req_valid(req_valid), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_rdata(rdata), .retain_req(retain_req), .retain_ok(retain_ok), .mem_addr(mem_addr),
    .select_low_active_n(sl_n), .select_high_active(sh), .write_strobe_n(we_n), .output_enable_n(oe_n),
    .mem_data_in(bus), .mem_data_out(dout), .mem_data_oe_n(d_oe_n));
  asrc_mem asrc_mem_i (.mem_addr(mem_addr), .sel_n(sl_n), .sel_h(sh), .we_n(we_n), .oe_n(oe_n),
    .host_d(dout), .host_oe_n(d_oe_n), .bus(bus));
  always #2 clock = ~clock;
  task chk(input logic [16:0] seen, input logic [16:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task req(input logic w, input logic [16:0] a, input logic [7:0] d);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 100) begin
      @(negedge clock);
      n++;
    end
    chk(req_ready, 17'h00001);
    req_valid = 1'b1;
    req_write = w;
    req_addr = a;
    req_wdata = d;
    @(negedge clock);
    req_valid = 1'b0;
    chk(req_ready, 17'h00000);
    chk(mem_addr, a);
    if (w) chk({d_oe_n, dout}, {9'h000, d});
  endtask
  task rd(input logic [16:0] a, input logic [7:0] exp);
    int n;
    req(1'b0, a, 8'h00);
    n = 0;
    while (rsp_valid !== 1'b1 && n < 40) begin
      @(negedge clock);
      n++;
    end
    chk(rsp_valid, 17'h00001);
    chk(rdata, exp);
  endtask
  task t_reset;
    chk({sl_n, sh, we_n, oe_n, d_oe_n, retain_ok}, 17'h0002E);
    chk({rsp_valid, mem_addr}, 17'h00000);
  endtask
  task t_rw;
    // Address 0 twice: the later write must win
    req(1'b1, 17'h00000, 8'h3C);
    req(1'b1, 17'h1FFFF, 8'hC3);
    req(1'b1, 17'h0AAAA, 8'h5A);
    req(1'b1, 17'h00000, 8'hA5);
    rd(17'h00000, 8'hA5);
    rd(17'h1FFFF, 8'hC3);
    rd(17'h0AAAA, 8'h5A);
  endtask
  task t_retain;
    repeat (40) @(negedge clock);
    retain_req = 1'b1;
    repeat (3) @(negedge clock);
    chk(retain_ok, 17'h00001);
    chk(req_ready, 17'h00000);
    retain_req = 1'b0;
    repeat (2) @(negedge clock);
    chk(retain_ok, 17'h00000);
  endtask
  task print_verdict;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    #20000;
    error_cnt++;
    print_verdict;
  end
  initial begin
    repeat (10) @(negedge clock);
    rstn = 1'b1;
    t_reset;
    t_rw;
    t_retain;
    print_verdict;
  end
endmodule // async_sram_cycle_timing_tb
bind asrc_ctrl asrc_chk asrc_chk_i (.clock(clock), .rstn(rstn), .rsp_valid(rsp_valid), .retain_ok(retain_ok),
  .mem_addr(mem_addr), .select_low_active_n(select_low_active_n), .select_high_active(select_high_active),
  .write_strobe_n(write_strobe_n), .output_enable_n(output_enable_n), .mem_data_out(mem_data_out),
  .mem_data_oe_n(mem_data_oe_n));
